// [verilog/sync_serial_port_control.sv]
// serial port control: flags, pin takeover, clock hold, shift engine, bus slave
`timescale 1ns/10ps
`default_nettype none
module sync_serial_port_control
  import sync_serial_pkg::*;
#(
  parameter int SCK_HALF = SCK_HALF_CYCLES
)(
  // clock and reset
  input  wire logic        clock,
  input  wire logic        rst,
  // axi4-lite slave
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_awaddr,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  output logic [1:0]       s_axi_bresp,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  input  wire logic [31:0] s_axi_araddr,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  // general-purpose side of the pins
  input  wire pins_type    gpio_out,
  input  wire pins_type    gpio_oe_n,
  // pins
  input  wire pins_type    pin_in,
  output pins_type         pin_out,
  output pins_type         pin_oe_n,
  // interrupt
  output logic             irq
);
  if (SCK_HALF < 1 || SCK_HALF > 255)
  begin : g_chk
    $error("SCK_HALF out of range");
  end

  ////////////////////////////////////////////////////////////////////////////
  // signals
  logic            en_q, ckp_q;
  logic [3:0]      mode_q;
  logic            write_collision_flag_q, ovf_q, full_q, busy_q, sck_q;
  logic [7:0]      buf_q, shift_q, rx_q;
  logic [2:0]      cnt_q, stat_q, mask_q;
  logic [7:0]      div_q;
  pins_type        meta_q, sync_q, prev_q;
  logic            aw_hold_q, w_hold_q, bvalid_q, rvalid_q;
  logic [7:0]      awaddr_q, wdata_q;
  logic            wstrb0_q;
  logic [1:0]      bresp_q, rresp_q;
  logic [31:0]     rdata_q;
  proto_type       proto;
  logic            do_write, wr_ctrl, wr_buf, wr_stat, wr_mask, rd_take, rd_buf;
  logic            ss_act, lead, trail, byte_done, ovf_set, write_collision_flag_set;
  logic            map_w, map_r;

  assign proto    = decode_proto(mode_q);
  assign do_write = aw_hold_q && w_hold_q && !bvalid_q;
  assign map_w    = awaddr_q == OFS_CTRL || awaddr_q == OFS_BUF ||
                    awaddr_q == OFS_STAT || awaddr_q == OFS_MASK;
  assign wr_ctrl  = do_write && wstrb0_q && awaddr_q == OFS_CTRL;
  assign wr_buf   = do_write && wstrb0_q && awaddr_q == OFS_BUF;
  assign wr_stat  = do_write && wstrb0_q && awaddr_q == OFS_STAT;
  assign wr_mask  = do_write && wstrb0_q && awaddr_q == OFS_MASK;
  assign rd_take  = s_axi_arvalid && !rvalid_q;
  assign map_r    = s_axi_araddr[7:0] == OFS_CTRL || s_axi_araddr[7:0] == OFS_BUF ||
                    s_axi_araddr[7:0] == OFS_STAT || s_axi_araddr[7:0] == OFS_MASK;
  assign rd_buf   = rd_take && s_axi_araddr[7:0] == OFS_BUF;

  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisers
  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      meta_q <= '0;
      sync_q <= '0;
      prev_q <= '0;
    end
    else
    begin
      meta_q <= pin_in;
      sync_q <= meta_q;
      prev_q <= sync_q;
    end
  end

  // select is active low; the no-select slave mode treats it as always on
  assign ss_act = (mode_q == MODE_SPI_SLAVE_NOSS) || !sync_q.ss;
  // slave edges seen on the sampled clock pin
  assign lead  = (proto == PROTO_SPI_SLAVE) && ss_act &&
                 sync_q.sck != prev_q.sck && sync_q.sck != ckp_q;
  assign trail = (proto == PROTO_SPI_SLAVE) && ss_act &&
                 sync_q.sck != prev_q.sck && sync_q.sck == ckp_q;

  ////////////////////////////////////////////////////////////////////////////
  // shift engine
  logic m_tick, m_lead, m_trail, i_rise, i_start;
  assign m_tick  = (proto == PROTO_SPI_MASTER) && busy_q && div_q == 8'(SCK_HALF - 1);
  assign m_lead  = m_tick && sck_q == ckp_q;
  assign m_trail = m_tick && sck_q != ckp_q;
  assign i_rise  = (proto == PROTO_I2C) && sync_q.sck && !prev_q.sck;
  assign i_start = (proto == PROTO_I2C) && sync_q.sck && prev_q.sck &&
                   !sync_q.sdi && prev_q.sdi;
  assign byte_done = en_q && cnt_q == 3'h7 &&
                     (m_trail || trail || (i_rise && !i_start));
  assign write_collision_flag_set  = wr_buf && busy_q;

  always_ff @(posedge clock)
  begin
    if (rst || !en_q)
    begin
      busy_q  <= 1'b0;
      cnt_q   <= 3'h0;
      div_q   <= 8'h00;
      sck_q   <= 1'b0;
      shift_q <= BUF_RESET;
      rx_q    <= BUF_RESET;
    end
    else
    begin
      if (!busy_q)
        sck_q <= ckp_q;
      // master starts only on a buffer write
      if (wr_buf && !busy_q)
      begin
        shift_q <= wdata_q;
        busy_q  <= (proto == PROTO_SPI_MASTER);
        div_q   <= 8'h00;
      end
      if (proto == PROTO_SPI_MASTER && busy_q)
        div_q <= m_tick ? 8'h00 : div_q + 8'h01;
      if (m_tick)
        sck_q <= !sck_q;
      if (proto == PROTO_SPI_SLAVE && !ss_act)
        cnt_q <= 3'h0;
      if (m_lead || lead)
      begin
        rx_q   <= {rx_q[6:0], sync_q.sdi};
        busy_q <= 1'b1;
      end
      if (m_trail || trail)
      begin
        shift_q <= {shift_q[6:0], 1'b0};
        cnt_q   <= cnt_q + 3'h1;
        if (cnt_q == 3'h7)
          busy_q <= 1'b0;
      end
      if (i_start)
        cnt_q <= 3'h0;
      else if (i_rise)
      begin
        rx_q  <= {rx_q[6:0], sync_q.sdi};
        cnt_q <= cnt_q + 3'h1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // receive buffer and overflow
  logic [7:0] rx_byte;
  assign rx_byte = (proto == PROTO_I2C) ? {rx_q[6:0], sync_q.sdi} : rx_q;
  assign ovf_set = byte_done && full_q && (proto != PROTO_SPI_MASTER);

  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      buf_q  <= BUF_RESET;
      full_q <= 1'b0;
    end
    else if (byte_done && !ovf_set)
    begin
      buf_q  <= rx_byte;
      full_q <= 1'b1;
    end
    else if (rd_buf)
      full_q <= 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////////
  // control register and flags
  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      en_q   <= 1'b0;
      ckp_q  <= 1'b0;
      mode_q <= MODE_RESET;
    end
    else if (wr_ctrl)
    begin
      en_q   <= wdata_q[EN_BIT];
      ckp_q  <= wdata_q[CKP_BIT];
      mode_q <= wdata_q[3:0];
    end
  end

  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      write_collision_flag_q <= 1'b0;
      ovf_q  <= 1'b0;
    end
    else
    begin
      if (write_collision_flag_set)
        write_collision_flag_q <= 1'b1;
      else if (wr_ctrl && !wdata_q[WRITE_COLLISION_FLAG_BIT])
        write_collision_flag_q <= 1'b0;
      if (ovf_set)
        ovf_q <= 1'b1;
      else if (wr_ctrl && !wdata_q[OVF_BIT])
        ovf_q <= 1'b0;
    end
  end

  // interrupt status, write one to clear, set wins
  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      stat_q <= IRQ_RESET;
      mask_q <= IRQ_RESET;
    end
    else
    begin
      stat_q <= (stat_q & ~({3{wr_stat}} & wdata_q[2:0])) |
                {ovf_set, write_collision_flag_set, byte_done};
      if (wr_mask)
        mask_q <= wdata_q[2:0];
    end
  end
  assign irq = |(stat_q & mask_q);

  ////////////////////////////////////////////////////////////////////////////
  // pin takeover
  always_comb
  begin
    pin_out  = gpio_out;
    pin_oe_n = gpio_oe_n;
    if (en_q && proto == PROTO_I2C)
    begin
      pin_out.sck  = 1'b0;
      pin_out.sdi  = 1'b0;
      pin_oe_n.sck = ckp_q;
      pin_oe_n.sdi = 1'b1;
    end
    else if (en_q)
    begin
      // directions stay with software
      pin_out.sck = sck_q;
      pin_out.sdo = shift_q[7];
      pin_out.sdi = 1'b0;
      if (mode_q != MODE_SPI_SLAVE_NOSS)
        pin_out.ss = 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // axi4-lite slave
  assign s_axi_awready = !aw_hold_q && !bvalid_q;
  assign s_axi_wready  = !w_hold_q && !bvalid_q;
  assign s_axi_bvalid  = bvalid_q;
  assign s_axi_bresp   = bresp_q;
  assign s_axi_arready = !rvalid_q;
  assign s_axi_rvalid  = rvalid_q;
  assign s_axi_rdata   = rdata_q;
  assign s_axi_rresp   = rresp_q;

  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      aw_hold_q <= 1'b0;
      w_hold_q  <= 1'b0;
      awaddr_q  <= 8'h00;
      wdata_q   <= 8'h00;
      wstrb0_q  <= 1'b0;
      bvalid_q  <= 1'b0;
      bresp_q   <= RESP_OKAY;
    end
    else
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_hold_q <= 1'b1;
        awaddr_q  <= s_axi_awaddr[7:0];
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_hold_q <= 1'b1;
        wdata_q  <= s_axi_wdata[7:0];
        wstrb0_q <= s_axi_wstrb[0];
      end
      if (do_write)
      begin
        aw_hold_q <= 1'b0;
        w_hold_q  <= 1'b0;
        bvalid_q  <= 1'b1;
        bresp_q   <= map_w ? RESP_OKAY : RESP_SLVERR;
      end
      else if (bvalid_q && s_axi_bready)
        bvalid_q <= 1'b0;
    end
  end

  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      rvalid_q <= 1'b0;
      rdata_q  <= 32'h0000_0000;
      rresp_q  <= RESP_OKAY;
    end
    else if (rd_take)
    begin
      rvalid_q <= 1'b1;
      rresp_q  <= map_r ? RESP_OKAY : RESP_SLVERR;
      if (s_axi_araddr[7:0] == OFS_CTRL)
        rdata_q <= {24'h0, write_collision_flag_q, ovf_q, en_q, ckp_q, mode_q};
      else if (s_axi_araddr[7:0] == OFS_BUF)
        rdata_q <= {24'h0, buf_q};
      else if (s_axi_araddr[7:0] == OFS_STAT)
        rdata_q <= {29'h0, stat_q};
      else if (s_axi_araddr[7:0] == OFS_MASK)
        rdata_q <= {29'h0, mask_q};
      else
        rdata_q <= 32'h0000_0000;
    end
    else if (rvalid_q && s_axi_rready)
      rvalid_q <= 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);

  AST_WRITE_COLLISION_FLAG_SET: assert property (wr_buf && busy_q |=> write_collision_flag_q)
    else $error("collision flag not set");
  AST_OVF_SPI: assert property (byte_done && full_q && proto == PROTO_SPI_SLAVE
    |=> ovf_q && $stable(buf_q))
    else $error("spi overflow missed or byte kept");
  AST_NO_OVF_MASTER: assert property (proto == PROTO_SPI_MASTER && !ovf_q
    && !wr_ctrl |=> !ovf_q)
    else $error("overflow set in master mode");
  AST_OVF_I2C: assert property (byte_done && full_q && proto == PROTO_I2C
    |=> ovf_q)
    else $error("i2c overflow missed");
  AST_SPI_PINS: assert property (en_q && proto == PROTO_SPI_MASTER
    |-> pin_out.sck == sck_q && pin_out.sdo == shift_q[7])
    else $error("spi pins not taken");
  AST_GPIO: assert property (!en_q |-> pin_out == gpio_out
    && pin_oe_n == gpio_oe_n)
    else $error("pins not returned to gpio");
  AST_I2C_PINS: assert property (en_q && proto == PROTO_I2C
    |-> !pin_out.sck && !pin_out.sdi && pin_oe_n.sdi)
    else $error("i2c pins not taken");
  AST_CKP_HOLD: assert property (en_q && proto == PROTO_I2C
    |-> pin_oe_n.sck == ckp_q)
    else $error("clock hold wrong");
  AST_SS_FREE: assert property (en_q && mode_q == MODE_SPI_SLAVE_NOSS
    |-> pin_out.ss == gpio_out.ss)
    else $error("select pin not free");
  AST_FLAG_KEEP: assert property (write_collision_flag_q && wr_ctrl && wdata_q[WRITE_COLLISION_FLAG_BIT]
    |=> write_collision_flag_q)
    else $error("flag cleared by a one");
endmodule : sync_serial_port_control
`default_nettype wire

// [verilog/sync_serial_pkg.sv]
// constants, types and helpers of the serial port control block
// Behaviour
// - writing the buffer during a transfer sets the write collision flag, sticky
// - SPI slave: byte arriving while buffer unread sets overflow, new byte lost
// - SPI master never sets overflow; transfers start on buffer write
// - I2C: byte received while buffer full sets overflow, sticky
// - SPI: enable bit hands clock, data out, data in, select pins to port
// - enable bit clear returns pins to general-purpose I/O
// - I2C: enable bit hands SDA and SCL pins to port
// - I2C slave: clock control 1 releases SCL, 0 holds it low
// - mode codes 0100/0101 are SPI slave; 0101 frees the select pin
package sync_serial_pkg;
  // register byte offsets
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_BUF  = 8'h04;
  localparam logic [7:0] OFS_STAT = 8'h08;
  localparam logic [7:0] OFS_MASK = 8'h0C;
  // control fields
  localparam int WRITE_COLLISION_FLAG_BIT = 7;
  localparam int OVF_BIT  = 6;
  localparam int EN_BIT   = 5;
  localparam int CKP_BIT  = 4;
  localparam logic [3:0] CTRL_RESET = 4'h0;
  localparam logic [3:0] MODE_RESET = 4'h0;
  localparam logic [7:0] BUF_RESET  = 8'h00;
  // mode codes
  localparam logic [3:0] MODE_SPI_SLAVE      = 4'h4;
  localparam logic [3:0] MODE_SPI_SLAVE_NOSS = 4'h5;
  localparam logic [3:0] MODE_SPI_MASTER_ALT = 4'hA;
  // interrupt status bits
  localparam int IRQ_DONE = 0;
  localparam int IRQ_WRITE_COLLISION_FLAG = 1;
  localparam int IRQ_OVF  = 2;
  localparam logic [2:0] IRQ_RESET = 3'h0;
  // bus responses
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // master clock half period in system cycles
  localparam int SCK_HALF_CYCLES = 4;
  typedef struct packed {
    logic ss;
    logic sdo;
    logic sdi;
    logic sck;
  } pins_type;
  typedef enum {PROTO_SPI_MASTER, PROTO_SPI_SLAVE, PROTO_I2C} proto_type;
  function automatic proto_type decode_proto(input logic [3:0] mode);
    if (mode <= 4'h3 || mode == MODE_SPI_MASTER_ALT)
      decode_proto = PROTO_SPI_MASTER;
    else if (mode == MODE_SPI_SLAVE || mode == MODE_SPI_SLAVE_NOSS)
      decode_proto = PROTO_SPI_SLAVE;
    else
      decode_proto = PROTO_I2C;
  endfunction : decode_proto
endpackage : sync_serial_pkg

// [dv/serial_peer.sv]
// far-side peer: spi slave, spi master, i2c sender
`timescale 1ns/10ps
`default_nettype none
module serial_peer
  import sync_serial_pkg::*;
(
  // clock and role
  input  wire logic       clock,
  input  wire logic [1:0] role,
  // block side
  input  wire pins_type   pin_out,
  output var  pins_type   pin_in
);
  logic [7:0] tx_q, rx_q;
  logic [2:0] cnt_q;
  logic       sck_q, busy;
  initial
  begin
    pin_in = 4'h8;
    tx_q = 8'h00;
    cnt_q = 3'h0;
    busy = 1'b0;
  end
  ////////////////////////////////////////
  // slave answer; released data toggles
  always @(posedge clock)
  begin
    sck_q <= pin_out.sck;
    if (role == 2'h0)
    begin
      pin_in.sdi <= tx_q[~cnt_q];
      if (pin_out.sck && !sck_q)
        rx_q <= {rx_q[6:0], pin_out.sdo};
      if (!pin_out.sck && sck_q)
        cnt_q <= cnt_q + 3'h1;
    end
    else if (role == 2'h1 && !busy)
      pin_in.sdi <= ~pin_in.sdi;
  end
  ////////////////////////////////////////
  task automatic hold(input int n);
    repeat (n) @(posedge clock);
  endtask : hold
  // one master frame, clock still outside
  task automatic spi_byte(input logic [7:0] b, input logic sel);
    busy = 1'b1;
    pin_in.ss <= ~sel;
    for (int i = 7; i >= 0; i--)
    begin
      pin_in.sdi <= b[i];
      hold(4);
      pin_in.sck <= 1'b1;
      hold(4);
      pin_in.sck <= 1'b0;
    end
    hold(4);
    pin_in.ss <= 1'b1;
    busy = 1'b0;
  endtask : spi_byte
  // start, then eight bits msb first
  task automatic i2c_byte(input logic [7:0] b);
    pin_in.sdi <= 1'b1;
    hold(2);
    pin_in.sck <= 1'b1;
    hold(4);
    pin_in.sdi <= 1'b0;
    for (int i = 7; i >= 0; i--)
    begin
      hold(4);
      pin_in.sck <= 1'b0;
      hold(2);
      pin_in.sdi <= b[i];
      hold(2);
      pin_in.sck <= 1'b1;
    end
    hold(4);
    pin_in.sck <= 1'b0;
    hold(2);
    pin_in.sdi <= 1'b1;
  endtask : i2c_byte
endmodule : serial_peer
`default_nettype wire

// [dv/tb_sync_serial_port_control.sv]
// self-checking bench of the serial port control block
`timescale 1ns/10ps
`default_nettype none
module tb_sync_serial_port_control
  import sync_serial_pkg::*;
;
  logic        clock, rst, irq, s_axi_awvalid, s_axi_awready, s_axi_wvalid;
  logic        s_axi_wready, s_axi_bvalid, s_axi_bready, s_axi_arvalid;
  logic        s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata, rd;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp, role, rsp;
  logic [7:0]  b;
  pins_type    gpio_out, gpio_oe_n, pin_out, pin_oe_n, peer_pins;
  wire pins_type pin_in;
  int          err_total, total_checks, cycles, seed, exp_q[$];
  sync_serial_port_control #(.SCK_HALF(8)) DUT (.clock, .rst,
    .s_axi_awvalid, .s_axi_awready, .s_axi_awaddr, .s_axi_wvalid, .s_axi_wready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_bvalid, .s_axi_bready, .s_axi_bresp,
    .s_axi_arvalid, .s_axi_arready, .s_axi_araddr, .s_axi_rvalid, .s_axi_rready,
    .s_axi_rdata, .s_axi_rresp, .gpio_out, .gpio_oe_n, .pin_in, .pin_out,
    .pin_oe_n, .irq);
  serial_peer peer (.clock, .role, .pin_out, .pin_in(peer_pins));
  // wired level of the open-drain clock line
  assign pin_in = {peer_pins[3:1],
                   peer_pins.sck & (role != 2'h2 || pin_oe_n.sck || pin_out.sck)};
  ////////////////////////////////////////
  initial
  begin
    clock = 1'b0;
    forever #50 clock = ~clock;
  end
  always @(posedge clock)
  begin
    cycles <= cycles + 1;
    if (cycles == 6000)
    begin
      err_total++;
      wrap_up();
    end
  end
  ////////////////////////////////////////
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : wrap_up
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    total_checks++;
    if (g !== e)
    begin
      err_total++;
      $display("unexpected %s: expected %h seen %h", n, e, g);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    s_axi_awaddr <= {24'h0, a};
    s_axi_wdata <= {24'h0, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    do
    begin
      @(posedge clock);
      if (s_axi_awready)
        s_axi_awvalid <= 1'b0;
      if (s_axi_wready)
        s_axi_wvalid <= 1'b0;
    end
    while (!s_axi_bvalid);
    rsp = s_axi_bresp;
  endtask : wr
  task automatic rchk(input logic [7:0] a, input logic [31:0] e, input string n);
    s_axi_araddr <= {24'h0, a};
    s_axi_arvalid <= 1'b1;
    do
    begin
      @(posedge clock);
      if (s_axi_arready)
        s_axi_arvalid <= 1'b0;
    end
    while (!s_axi_rvalid);
    rd = s_axi_rdata;
    rsp = s_axi_rresp;
    chk(n, e, rd);
  endtask : rchk
  task automatic wait_irq;
    for (int i = 0; i < 400 && irq !== 1'b1; i++)
      @(posedge clock);
    chk("irq", 32'h1, 32'(irq));
  endtask : wait_irq
  ////////////////////////////////////////
  initial
  begin
    seed = 80556;
    {err_total, total_checks, cycles} = 0;
    rst = 1'b1;
    role = 2'h0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_arvalid} = 3'h0;
    {s_axi_awaddr, s_axi_wdata, s_axi_araddr} = 96'h0;
    s_axi_wstrb = 4'h1;
    {s_axi_bready, s_axi_rready} = 2'h3;
    gpio_out = 4'($random(seed));
    gpio_oe_n = 4'($random(seed));
    repeat (4) @(posedge clock);
    rst <= 1'b0;
    rchk(OFS_CTRL, 32'h0, "ctrl");
    rchk(8'h10, 32'h0, "unmap");
    chk("rresp", 32'(RESP_SLVERR), 32'(rsp));
    wr(8'h10, 8'hFF);
    chk("bresp", 32'(RESP_SLVERR), 32'(rsp));
    s_axi_wstrb <= 4'h0;
    wr(OFS_MASK, 8'h07);
    s_axi_wstrb <= 4'h1;
    rchk(OFS_MASK, 32'h0, "strb");
    chk("pins", 32'({gpio_out, gpio_oe_n}), 32'({pin_out, pin_oe_n}));
    $display("end test reset");
    wr(OFS_MASK, 8'h01);
    wr(OFS_CTRL, 8'h20);
    chk("spi", 32'({gpio_oe_n, 2'h0}), 32'({pin_oe_n, pin_out.ss, pin_out.sdi}));
    for (int k = 0; k < 3; k++)
    begin
      b = 8'($random(seed));
      peer.tx_q = ~b;
      exp_q = {int'(peer.tx_q)};
      wr(OFS_BUF, b);
      if (k == 2)
        wr(OFS_BUF, 8'hFF);
      wait_irq();
      chk("peer", 32'(b), 32'(peer.rx_q));
      wr(OFS_STAT, 8'h01);
      chk("irq", 32'h0, 32'(irq));
    end
    rchk(OFS_BUF, exp_q[0], "buf");
    rchk(OFS_CTRL, 32'hA0, "write_collision_flag");
    wr(OFS_MASK, 8'h03);
    chk("irq", 32'h1, 32'(irq));
    wr(OFS_STAT, 8'h02);
    chk("irq", 32'h0, 32'(irq));
    wr(OFS_CTRL, 8'hE0);
    rchk(OFS_CTRL, 32'hA0, "keep");
    wr(OFS_CTRL, 8'h20);
    rchk(OFS_CTRL, 32'h20, "clear");
    wr(OFS_CTRL, 8'h2A);
    b = 8'($random(seed));
    peer.tx_q = 8'h3C;
    wr(OFS_BUF, b);
    wait_irq();
    chk("alt", 32'(b), 32'(peer.rx_q));
    wr(OFS_STAT, 8'h01);
    rchk(OFS_BUF, 32'h3C, "altbuf");
    rchk(OFS_CTRL, 32'h2A, "altflags");
    $display("end test spi master");
    wr(OFS_CTRL, 8'h24);
    role = 2'h1;
    exp_q.delete();
    for (int k = 0; k < 3; k++)
    begin
      b = 8'($random(seed));
      exp_q.push_back(int'(b));
      peer.spi_byte(b, 1'b1);
      repeat (4) @(posedge clock);
      if (k == 0)
        rchk(OFS_BUF, exp_q.pop_front(), "rx");
    end
    rchk(OFS_BUF, exp_q[0], "kept");
    rchk(OFS_CTRL, 32'h64, "ovf");
    wr(OFS_CTRL, 8'h25);
    chk("ss", 32'({gpio_out.ss, gpio_oe_n.ss}), 32'({pin_out.ss, pin_oe_n.ss}));
    b = 8'($random(seed));
    peer.spi_byte(b, 1'b0);
    repeat (4) @(posedge clock);
    rchk(OFS_BUF, 32'(b), "nosel");
    $display("end test spi slave");
    role = 2'h2;
    exp_q.delete();
    wr(OFS_CTRL, 8'h26);
    chk("held", 32'h1, 32'({pin_oe_n.sck, pin_out.sck, pin_oe_n.sdi}));
    wr(OFS_CTRL, 8'h36);
    chk("free", 32'h1, 32'(pin_oe_n.sck));
    for (int k = 0; k < 2; k++)
    begin
      b = 8'($random(seed));
      exp_q.push_back(int'(b));
      peer.i2c_byte(b);
    end
    repeat (4) @(posedge clock);
    rchk(OFS_BUF, exp_q[0], "i2c");
    rchk(OFS_CTRL, 32'h76, "i2cov");
    $display("end test i2c");
    gpio_out <= 4'($random(seed));
    wr(OFS_CTRL, 8'h06);
    chk("gpio", 32'({gpio_out, gpio_oe_n}), 32'({pin_out, pin_oe_n}));
    $display("end test disable");
    wrap_up();
  end
endmodule : tb_sync_serial_port_control
`default_nettype wire
